// ==== bioprt_pkg.sv ====
package bioprt_pkg;
  // ****************************************************************
  // File addresses
  // ****************************************************************
  localparam logic [4:0] first_port_addr  = 5'h05;
  localparam logic [4:0] second_port_addr = 5'h06;
  localparam logic [4:0] third_port_addr  = 5'h07;
  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int         port_width        = 8;
  localparam int         first_port_pins_n = 4;
  localparam logic [7:0] dir_reset_value   = 8'hff;
  localparam logic [7:0] latch_reset_value = 8'h00;
  localparam logic [7:0] read_zero         = 8'h00;
  localparam logic [7:0] first_port_mask   = 8'h0f;
endpackage

// ==== bioprt_pin_bank.sv ====
`timescale 1ns/1ps
module bioprt_pin_bank #(
  parameter int          width = 8,
  parameter logic [7:0]  mask  = 8'hff
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             por_pulse,
  input  wire logic             clk_en,
  input  wire logic             wr_data,
  input  wire logic             wr_dir,
  input  wire logic [width-1:0] wdata,
  input  wire logic [width-1:0] pin_in,
  output logic      [width-1:0] pin_out,
  output logic      [width-1:0] pin_oe,
  output logic      [width-1:0] rd_value
);
  logic [width-1:0] latch_ff;
  logic [width-1:0] nxt_latch;
  logic [width-1:0] dir_ff;
  logic [width-1:0] nxt_dir;
  logic [width-1:0] out_ff;
  logic [width-1:0] nxt_out;
  logic [width-1:0] oe_ff;
  logic [width-1:0] nxt_oe;
  logic [width-1:0] msk;

  assign msk = mask[width-1:0];
  // Pins read live, never the latch; unused bits forced low
  assign rd_value = pin_in & msk;

  always_comb begin
    nxt_latch = latch_ff;
    nxt_dir   = dir_ff;
    if (por_pulse) begin
      nxt_latch = bioprt_pkg::latch_reset_value[width-1:0];
      nxt_dir   = bioprt_pkg::dir_reset_value[width-1:0];
    end else if (clk_en) begin
      if (wr_data) begin
        nxt_latch = wdata & msk;
      end
      if (wr_dir) begin
        nxt_dir = wdata | ~msk;
      end
    end
    // Per bit: one tristates, zero drives the latch
    nxt_oe  = ~nxt_dir & msk;
    nxt_out = nxt_latch & nxt_oe;
  end

  // Latch survives async reset; only power-on clears it
  always_ff @(posedge clock) begin
    latch_ff <= nxt_latch;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dir_ff <= bioprt_pkg::dir_reset_value[width-1:0];
      oe_ff  <= '0;
      out_ff <= '0;
    end else begin
      dir_ff <= nxt_dir;
      oe_ff  <= nxt_oe;
      out_ff <= nxt_out;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe  = oe_ff;
endmodule // bioprt_pin_bank

// ==== bioprt_ports.sv ====
`timescale 1ns/1ps
module bioprt_ports #(
  parameter bit has_third_port = 1'b1
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       power_on,
  input  wire logic       clk_en,
  input  wire logic [4:0] file_addr,
  input  wire logic       file_rd,
  input  wire logic       file_wr,
  input  wire logic [7:0] file_wdata,
  input  wire logic       direction_load_instruction,
  input  wire logic [7:0] accumulator,
  output logic      [7:0] file_rdata,
  output logic            file_hit,
  input  wire logic [3:0] first_port_bits_in,
  output logic      [3:0] first_port_bits_out,
  output logic      [3:0] first_port_bits_oe,
  input  wire logic [7:0] second_port_in,
  output logic      [7:0] second_port_out,
  output logic      [7:0] second_port_oe,
  input  wire logic [7:0] third_port_in,
  output logic      [7:0] third_port_out,
  output logic      [7:0] third_port_oe
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  logic       sel_a;
  logic       sel_b;
  logic       sel_c;
  logic       wr_a;
  logic       wr_b;
  logic       wr_c;
  logic       dir_a;
  logic       dir_b;
  logic       dir_c;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rd_c;
  logic [7:0] gp_ff;
  logic [7:0] nxt_gp;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       hit_ff;
  logic       nxt_hit;

  // Plain hit on each port address
  always_comb begin
    sel_a = 1'b0;
    sel_b = 1'b0;
    sel_c = 1'b0;
    if (file_addr == bioprt_pkg::first_port_addr) begin
      sel_a = 1'b1;
    end else if (file_addr == bioprt_pkg::second_port_addr) begin
      sel_b = 1'b1;
    end else if (file_addr == bioprt_pkg::third_port_addr) begin
      sel_c = 1'b1;
    end
  end

  assign wr_a = file_wr & sel_a;
  assign wr_b = file_wr & sel_b;
  assign wr_c = file_wr & sel_c & has_third_port;
  // Direction writes come only from the instruction, never a file write
  assign dir_a = direction_load_instruction & sel_a;
  assign dir_b = direction_load_instruction & sel_b;
  assign dir_c = direction_load_instruction & sel_c & has_third_port;

  // ****************************************************************
  // Pin banks
  // ****************************************************************
  logic [3:0] a_out;
  logic [3:0] a_oe;
  logic [3:0] a_rd;
  logic [3:0] a_wd;
  logic [3:0] a_dir_wd;
  logic [3:0] a_wd_sel;

  assign a_wd     = file_wdata[3:0];
  assign a_dir_wd = accumulator[3:0];
  assign a_wd_sel = dir_a ? a_dir_wd : a_wd;

  bioprt_pin_bank #(
    .width (4),
    .mask  (bioprt_pkg::first_port_mask)
  ) u_bank_a (
    .clock     (clock),
    .resetn    (resetn),
    .por_pulse (power_on),
    .clk_en    (clk_en),
    .wr_data   (wr_a),
    .wr_dir    (dir_a),
    .wdata     (a_wd_sel),
    .pin_in    (first_port_bits_in),
    .pin_out   (a_out),
    .pin_oe    (a_oe),
    .rd_value  (a_rd)
  );
  assign rd_a = {4'h0, a_rd};

  bioprt_pin_bank #(
    .width (8),
    .mask  (8'hff)
  ) u_bank_b (
    .clock     (clock),
    .resetn    (resetn),
    .por_pulse (power_on),
    .clk_en    (clk_en),
    .wr_data   (wr_b),
    .wr_dir    (dir_b),
    .wdata     (dir_b ? accumulator : file_wdata),
    .pin_in    (second_port_in),
    .pin_out   (second_port_out),
    .pin_oe    (second_port_oe),
    .rd_value  (rd_b)
  );

  generate
    if (has_third_port) begin : g_third
      bioprt_pin_bank #(
        .width (8),
        .mask  (8'hff)
      ) u_bank_c (
        .clock     (clock),
        .resetn    (resetn),
        .por_pulse (power_on),
        .clk_en    (clk_en),
        .wr_data   (wr_c),
        .wr_dir    (dir_c),
        .wdata     (dir_c ? accumulator : file_wdata),
        .pin_in    (third_port_in),
        .pin_out   (third_port_out),
        .pin_oe    (third_port_oe),
        .rd_value  (rd_c)
      );
    end else begin : g_no_third
      // Outputs stay released; the address becomes storage instead
      assign third_port_out = 8'h00;
      assign third_port_oe  = 8'h00;
      assign rd_c           = gp_ff;
    end
  endgenerate

  assign first_port_bits_out = a_out;
  assign first_port_bits_oe  = a_oe;

  // ****************************************************************
  // Storage at 07h and read return
  // ****************************************************************
  always_comb begin
    nxt_gp    = gp_ff;
    nxt_rdata = rdata_ff;
    nxt_hit   = hit_ff;
    if (clk_en) begin
      if (!has_third_port && file_wr && sel_c) begin
        nxt_gp = file_wdata;
      end
      nxt_hit = file_rd & (sel_a | sel_b | sel_c);
      // Direction state is never put on the read path
      if (!file_rd) begin
        nxt_rdata = bioprt_pkg::read_zero;
      end else if (sel_a) begin
        nxt_rdata = rd_a;
      end else if (sel_b) begin
        nxt_rdata = rd_b;
      end else if (sel_c) begin
        nxt_rdata = rd_c;
      end else begin
        nxt_rdata = bioprt_pkg::read_zero;
      end
    end
  end

  // Storage keeps its value across resets, as a file register would
  always_ff @(posedge clock) begin
    gp_ff <= nxt_gp;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= bioprt_pkg::read_zero;
      hit_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      hit_ff   <= nxt_hit;
    end
  end

  assign file_rdata = rdata_ff;
  assign file_hit   = hit_ff;
endmodule // bioprt_ports

// ==== bioprt_pin_model.sv ====
`timescale 1ns/1ps
// ****
// Outside circuitry on one port
// ****
module bioprt_pin_model #(
  parameter int w = 8
) (
  input  logic [w-1:0] drv_out,
  input  logic [w-1:0] drv_oe,
  input  logic [w-1:0] ext_val,
  input  logic [w-1:0] ext_en,
  output logic [w-1:0] level
);
  // Outside drive beats the pin driver; idle pins pull up
  assign level = (ext_en & ext_val) | (~ext_en & drv_oe & drv_out)
               | (~ext_en & ~drv_oe);
endmodule // bioprt_pin_model

// ==== bioprt_ports_props.sv ====
`timescale 1ns/1ps
// ****
// Port checker
// ****
module bioprt_ports_props (
  input logic       clock,
  input logic       resetn,
  input logic       power_on,
  input logic       clk_en,
  input logic [4:0] file_addr,
  input logic       file_rd,
  input logic       file_wr,
  input logic [7:0] file_wdata,
  input logic       direction_load_instruction,
  input logic [7:0] accumulator,
  input logic [7:0] file_rdata,
  input logic       file_hit,
  input logic [3:0] first_port_bits_in,
  input logic [3:0] first_port_bits_oe,
  input logic [7:0] second_port_in,
  input logic [7:0] second_port_out,
  input logic [7:0] second_port_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_rd(a); clk_en && file_rd && file_addr == a; endsequence
  sequence s_dl(a);
    clk_en && direction_load_instruction && file_addr == a;
  endsequence
  chk_read_pins:
    assert property (s_rd(5'h06) |=> file_rdata == $past(second_port_in))
    else $error("bad pin read");
  chk_read_first:
    assert property (s_rd(5'h05) |=>
      file_rdata == {4'h0, $past(first_port_bits_in)}) else $error("bad a");
  chk_unmapped_read:
    assert property (clk_en && file_rd && file_addr > 5'h07 |=>
      file_rdata == 8'h00 && !file_hit) else $error("bad unmapped");
  chk_idle_zero:
    assert property (clk_en && !file_rd |=>
      file_rdata == 8'h00 && !file_hit) else $error("bad idle");
  chk_dir_load:
    assert property (s_dl(5'h06) |=>
      second_port_oe == ~$past(accumulator)) else $error("bad dir");
  chk_dir_first:
    assert property (s_dl(5'h05) |=>
      first_port_bits_oe == ~$past(accumulator[3:0])) else $error("bad dir a");
  chk_drive_latch:
    assert property (clk_en && file_wr && file_addr == 5'h06 && !power_on
      && !direction_load_instruction |=>
      second_port_out == ($past(file_wdata) & second_port_oe))
    else $error("bad drive");
  chk_latch_hold:
    assert property (!(clk_en && (file_wr || direction_load_instruction)
      && file_addr == 5'h06) && !power_on |=> $stable(second_port_out))
    else $error("bad hold");
  chk_power_dir:
    assert property (power_on |=>
      second_port_oe == 8'h00 && first_port_bits_oe == 4'h0)
    else $error("bad power dir");
  chk_reset_dir:
    assert property ($rose(resetn) |-> second_port_oe == 8'h00)
    else $error("bad reset dir");
endmodule // bioprt_ports_props

// ==== bioprt_ports_tb.sv ====
`timescale 1ns/1ps
module bioprt_ports_tb;
  logic       clock, resetn, power_on, clk_en, file_rd, file_wr, file_hit;
  logic       direction_load_instruction;
  logic [4:0] file_addr;
  logic [7:0] file_wdata, accumulator, file_rdata, ev_b, ee_b;
  logic [7:0] second_port_in, second_port_out, second_port_oe;
  logic [7:0] third_port_in, third_port_out, third_port_oe;
  logic [3:0] first_port_bits_in, first_port_bits_out;
  logic [3:0] first_port_bits_oe, ev_a, ee_a;
  int         fails = 0;
  int         total_checks = 0;
  // ****
  // Pins and design
  // ****
  bioprt_pin_model #(.w(4)) pins_a (.drv_out(first_port_bits_out),
    .drv_oe(first_port_bits_oe), .ext_val(ev_a), .ext_en(ee_a),
    .level(first_port_bits_in));
  bioprt_pin_model pins_b (.drv_out(second_port_out),
    .drv_oe(second_port_oe), .ext_val(ev_b), .ext_en(ee_b),
    .level(second_port_in));
  bioprt_pin_model pins_c (.drv_out(third_port_out), .drv_oe(third_port_oe),
    .ext_val(8'h00), .ext_en(8'h00), .level(third_port_in));
  bioprt_ports DUT (.clock, .resetn, .power_on, .clk_en, .file_addr,
    .file_rd, .file_wr, .file_wdata, .direction_load_instruction,
    .accumulator, .file_rdata, .file_hit, .first_port_bits_in,
    .first_port_bits_out, .first_port_bits_oe, .second_port_in,
    .second_port_out, .second_port_oe, .third_port_in, .third_port_out,
    .third_port_oe);
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  // ****
  // Bus cycles
  // ****
  task tick; @(posedge clock); #1; endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    file_addr = a; file_wdata = d; file_wr = 1; tick; file_wr = 0;
  endtask
  task dl(input logic [4:0] a, input logic [7:0] d);
    file_addr = a; accumulator = d; direction_load_instruction = 1;
    tick; direction_load_instruction = 0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    file_addr = a; file_rd = 1; tick; file_rd = 0;
    chk(file_rdata, e);
    chk({7'h0, file_hit}, {7'h0, a inside {[5'h05:5'h07]}});
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset;
    chk(second_port_oe, 8'h00);
    chk({first_port_bits_oe, third_port_oe[3:0]}, 8'h00);
    ev_b = 8'h3c; ee_b = 8'hff; ev_a = 4'ha; ee_a = 4'hf;
    rd(5'h06, 8'h3c);
    rd(5'h05, 8'h0a);
    rd(5'h07, 8'hff);
    $display("reset test done");
  endtask
  task t_mix;
    ee_b = 8'h00; wr(5'h06, 8'h55); dl(5'h06, 8'h0f);
    chk(second_port_oe, 8'hf0);
    chk(second_port_out, 8'h50);
    rd(5'h06, 8'h5f);
    ee_b = 8'h10; ev_b = 8'h00;
    rd(5'h06, 8'h4f);
    $display("mix test done");
  endtask
  task t_ports;
    ee_a = 4'h0; wr(5'h05, 8'hff); dl(5'h05, 8'hf0);
    chk({4'h0, first_port_bits_out}, 8'h0f);
    rd(5'h05, 8'h0f);
    ee_a = 4'h3; ev_a = 4'h0; rd(5'h05, 8'h0c);
    wr(5'h07, 8'ha5); dl(5'h07, 8'h00);
    chk(third_port_out, 8'ha5);
    chk(third_port_oe, 8'hff);
    rd(5'h07, 8'ha5);
    $display("port test done");
  endtask
  task t_rmw;
    ee_b = 8'h00; rd(5'h06, 8'h5f);
    wr(5'h06, file_rdata ^ 8'hff);
    chk(second_port_out, 8'ha0);
    rd(5'h08, 8'h00);
    rd(5'h04, 8'h00);
    dl(5'h08, 8'h00);
    chk(second_port_oe, 8'hf0);
    $display("rmw test done");
  endtask
  task t_resets;
    resetn = 0; #1;
    chk(second_port_oe, 8'h00);
    tick; resetn = 1; tick; dl(5'h06, 8'h00);
    chk(second_port_out, 8'ha0);
    power_on = 1; tick; power_on = 0;
    chk(second_port_oe, 8'h00);
    dl(5'h06, 8'h00);
    chk(second_port_out, 8'h00);
    $display("reset kinds test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {resetn, power_on, file_rd, file_wr, direction_load_instruction} = '0;
    clk_en = 1; file_addr = '0; file_wdata = '0; accumulator = '0;
    {ev_a, ee_a, ev_b, ee_b} = '0;
    repeat (2) @(posedge clock);
    #1 resetn = 1;
    t_reset; t_mix; t_ports; t_rmw; t_resets;
    print_verdict;
  end
  // A hang costs at most 2500 cycles
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
endmodule // bioprt_ports_tb
bind bioprt_ports bioprt_ports_props u_props (.clock, .resetn, .power_on,
  .clk_en, .file_addr, .file_rd, .file_wr, .file_wdata, .accumulator,
  .direction_load_instruction, .file_rdata, .file_hit, .second_port_in,
  .first_port_bits_in, .first_port_bits_oe, .second_port_out,
  .second_port_oe);
